// ===== src/flash_self_program_ctrl.sv
// Self-programming controller: control register, temporary page buffer, erase/write sequencing.
// Assumes the CPU presents store and load strobes with the pointer and data pair, and that
// the flash array answers each erase or write with a one-cycle done pulse.
//
// Overview of operation
// - Erase pattern plus store erases pointer page.
// - Load pattern plus store fills buffer word.
// - Write pattern plus store programs buffer page.
// - CPU stalled throughout erase and write.
// - Buffer cleared after write, clear, reset.
// - EEPROM write start discards partial buffer.
// - Enable arms store four cycles, then clears.
// - Enable stays set until flash operation ends.
// - Erase/write bits clear on completion or timeout.
// - Enable alone: store writes word, ignoring bit zero.
// - Signature read within three loads; store ignored.
// - Fuse/lock read within three loads, pointer-selected.
// - Only seven patterns, zero included, are valid commands.
// - Bits seven and six read zero.
// - EEPROM busy blocks commands and fuse reads.
// - Pointer low bits word, high bits page.
// - Load addresses bytes using pointer bits 1:0 for fuses, 2:0 for signature.
// - Pointer one lock, zero low fuse.
// - Programmed fuse bits read zero.
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_ctrl
  import flash_self_program_pkg::*;
#(
  parameter int WORD_BITS = 6,
  parameter int PAGE_BITS = 7,
  parameter int SIG_BYTES = 6
)(
  // Clock and reset
  input  wire logic                                       core_clk,
  input  wire logic                                       rst,
  // APB slave
  input  wire logic                                       psel,
  input  wire logic                                       penable,
  input  wire logic                                       pwrite,
  input  wire logic [11:0]                                paddr,
  input  wire logic [31:0]                                pwdata,
  output logic                                            pready,
  output logic                                            pslverr,
  output logic [31:0]                                     prdata,
  // CPU store and load instructions
  input  wire logic                                       storeReq,
  input  wire logic                                       loadReq,
  input  wire logic [15:0]                                pointer,
  input  wire logic [15:0]                                dataRegisterPair,
  output logic                                            cpuStall,
  output logic                                            loadValid,
  output logic [7:0]                                      loadData,
  // Neighbours
  input  wire logic                                       eepromWriteBusy,
  input  wire flash_self_program_pkg::fuseBits_t          fuseBits,
  input  wire logic [8*SIG_BYTES-1:0]                     signatureRow,
  // Flash array
  input  wire logic                                       flashDone,
  input  wire logic [WORD_BITS-1:0]                       flashBufAddr,
  output flash_self_program_pkg::flashCmd_t               flashCmd,
  output logic [15:0]                                     flashBufData
);
  import flash_self_program_pkg::*;

  localparam int WORDS = 1 << WORD_BITS;

  if (WORD_BITS < 1 || PAGE_BITS < 1 || WORD_BITS + PAGE_BITS > 15 || SIG_BYTES < 1 ||
      SIG_BYTES > 8)
  begin : g_bad_params
    $error("flash_self_program_ctrl: pointer fields or signature size out of range.");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [5:0]           ctrl_q, ctrl_d;
  logic [2:0]           armCnt_q, armCnt_d;
  flashOp_t             op_q, op_d;
  flashCmd_t            flashCmd_q;
  logic                 pready_q, pslverr_q;
  logic [31:0]          prdata_q;
  logic                 loadValid_q;
  logic [7:0]           loadData_q;
  logic [15:0]          bufData_q;
  logic                 eeBusy_q;
  logic [15:0]          bufMem [WORDS];
  logic [WORDS-1:0]     bufValid_q;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic                 apbDone    = psel & penable & pready_q;
  wire logic                 apbSetup   = psel & ~penable & ~pready_q;
  wire logic                 addrHit    = (paddr == CTRL_OFFSET);
  wire logic [5:0]           wrCmd      = pwdata[5:0];
  wire logic                 wrValid    = (wrCmd == CMD_LOAD) | (wrCmd == CMD_ERASE) |
                                          (wrCmd == CMD_WRITE) | (wrCmd == CMD_FUSE) |
                                          (wrCmd == CMD_CLEAR) | (wrCmd == CMD_SIG) |
                                          (wrCmd == CMD_NONE);
  // A control write is dropped while the EEPROM programs, so the window never opens.
  wire logic                 ctrlWrite  = apbDone & pwrite & addrHit & wrValid &
                                          ~eepromWriteBusy & (op_q == OP_IDLE);
  wire logic                 idle       = (op_q == OP_IDLE);
  wire logic                 storeWin   = idle & ctrl_q[ENABLE_BIT] & (armCnt_q != 3'd0);
  wire logic                 loadWin    = idle & ctrl_q[ENABLE_BIT] &
                                          (armCnt_q > STORE_WINDOW - LOAD_WINDOW);
  wire logic                 storeTake  = storeReq & storeWin & ~eepromWriteBusy;
  wire logic                 sigTake    = loadReq & loadWin & (ctrl_q == CMD_SIG);
  wire logic                 fuseTake   = loadReq & loadWin & (ctrl_q == CMD_FUSE) &
                                          ~eepromWriteBusy;
  wire logic                 startErase = storeTake & (ctrl_q == CMD_ERASE);
  wire logic                 startWrite = storeTake & (ctrl_q == CMD_WRITE);
  wire logic                 bufLoad    = storeTake & (ctrl_q == CMD_LOAD);
  // Word field skips pointer bit zero; page field sits just above it.
  wire logic [WORD_BITS-1:0] wordSel    = pointer[WORD_BITS:1];
  wire logic [PAGE_BITS-1:0] pageSel    = pointer[WORD_BITS+PAGE_BITS:WORD_BITS+1];
  wire logic                 eeStart    = eepromWriteBusy & ~eeBusy_q & (|bufValid_q);
  wire logic                 opDone     = ~idle & flashDone;
  wire logic                 bufClear   = (ctrlWrite & (wrCmd == CMD_CLEAR)) |
                                          (opDone & (op_q == OP_WRITE)) | eeStart;
  wire logic [7:0]           ctrlRead   = {2'b00, ctrl_q};
  wire logic [7:0]           fuseByte   = (pointer[1:0] == 2'd0) ? fuseBits.fuseLow  :
                                          (pointer[1:0] == 2'd1) ? fuseBits.lockBits :
                                          (pointer[1:0] == 2'd2) ? fuseBits.fuseExt  :
                                                                   fuseBits.fuseHigh;
  wire logic                 sigInRange = (int'(pointer[2:0]) < SIG_BYTES) &
                                          (pointer[15:3] == 13'd0);
  wire logic [7:0]           sigByte    = sigInRange ? signatureRow[8*pointer[2:0] +: 8] :
                                                       RESERVED_BYTE;

  // ----------------------------------------------------------------------
  // Control register and sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctrl_d   = ctrl_q;
    armCnt_d = (armCnt_q != 3'd0 && idle) ? armCnt_q - 3'd1 : armCnt_q;
    op_d     = op_q;
    unique case (op_q)
      OP_IDLE:
      begin
        if (ctrlWrite)
        begin
          ctrl_d   = wrCmd;
          armCnt_d = STORE_WINDOW;
        end
        else if (startErase || startWrite)
        begin
          op_d = startErase ? OP_ERASE : OP_WRITE;
        end
        else if (storeTake || sigTake || fuseTake || armCnt_q == 3'd1)
        begin
          ctrl_d   = CMD_NONE;
          armCnt_d = 3'd0;
        end
      end
      OP_ERASE, OP_WRITE:
      begin
        if (flashDone)
        begin
          op_d     = OP_IDLE;
          ctrl_d   = CMD_NONE;
          armCnt_d = 3'd0;
        end
      end
      default:
      begin
        op_d = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q   <= CTRL_RESET[5:0];
      armCnt_q <= 3'd0;
      op_q     <= OP_IDLE;
      flashCmd_q <= '0;
      eeBusy_q <= 1'b0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      armCnt_q <= armCnt_d;
      op_q     <= op_d;
      eeBusy_q <= eepromWriteBusy;
      flashCmd_q <= {(op_d != OP_IDLE), (op_d == OP_ERASE), (op_d == OP_WRITE),
                     ((idle && op_d != OP_IDLE) ? 16'(pageSel) : flashCmd_q.page)};
    end
  end

  // ----------------------------------------------------------------------
  // Temporary page buffer
  // ----------------------------------------------------------------------
  // Clearing by a valid map avoids a whole-array wipe; empty words read as erased.
  genvar gi;
  for (gi = 0; gi < WORDS; gi++)
  begin : g_buf
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        bufValid_q[gi] <= 1'b0;
      end
      else if (bufLoad && wordSel == WORD_BITS'(gi))
      begin
        bufValid_q[gi] <= 1'b1;
      end
      else if (bufClear)
      begin
        bufValid_q[gi] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (bufLoad)
    begin
      bufMem[wordSel] <= dataRegisterPair;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bufData_q <= ERASED_WORD;
    end
    else
    begin
      bufData_q <= bufValid_q[flashBufAddr] ? bufMem[flashBufAddr] : ERASED_WORD;
    end
  end

  // ----------------------------------------------------------------------
  // Load answers and APB slave
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      loadValid_q <= 1'b0;
      loadData_q  <= 8'h00;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      prdata_q    <= 32'h0000_0000;
    end
    else
    begin
      loadValid_q <= sigTake | fuseTake;
      loadData_q  <= sigTake ? sigByte : (fuseTake ? fuseByte : 8'h00);
      pready_q    <= apbSetup;
      pslverr_q   <= apbSetup & ~addrHit;
      prdata_q    <= (apbSetup && addrHit && !pwrite) ? {24'h00_0000, ctrlRead} :
                                                        32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign prdata          = prdata_q;
  assign cpuStall        = flashCmd_q.busy;
  assign loadValid       = loadValid_q;
  assign loadData        = loadData_q;
  assign flashCmd        = flashCmd_q;
  assign flashBufData    = bufData_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_erase_start;
    @(posedge core_clk) disable iff (rst)
      startErase |=> flashCmd.erase && cpuStall && flashCmd.page == 16'($past(pageSel));
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("Erase did not start.");
  property p_write_start;
    @(posedge core_clk) disable iff (rst)
      startWrite |=> flashCmd.write && flashCmd.busy;
  endproperty
  a_write_start: assert property (p_write_start) else $error("Write did not start.");
  property p_buf_load;
    @(posedge core_clk) disable iff (rst)
      bufLoad |=> bufValid_q[$past(wordSel)];
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("Buffer word not marked loaded.");
  property p_stall_hold;
    @(posedge core_clk) disable iff (rst)
      (cpuStall && !flashDone) |=> cpuStall && ctrl_q[ENABLE_BIT];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("Stall or enable dropped early.");
  property p_write_clears;
    @(posedge core_clk) disable iff (rst)
      (flashCmd.write && flashDone) |=> bufValid_q == '0 && !cpuStall && ctrl_q == CMD_NONE;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("Write end not clean.");
  property p_timeout;
    @(posedge core_clk) disable iff (rst)
      (ctrlWrite && wrCmd != CMD_NONE) ##1 (!storeReq && !loadReq)[*4] |=> ctrl_q == CMD_NONE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Arm window did not expire.");
  property p_ee_discard;
    @(posedge core_clk) disable iff (rst)
      $rose(eepromWriteBusy) |=> bufValid_q == '0;
  endproperty
  a_ee_discard: assert property (p_ee_discard) else $error("EEPROM start kept buffer.");
  // Only a disarmed register is judged, since an armed one may time out in the same cycle.
  property p_invalid_cmd;
    @(posedge core_clk) disable iff (rst)
      (apbDone && pwrite && !wrValid && idle && armCnt_q == 3'd0) |=> $stable(ctrl_q);
  endproperty
  a_invalid_cmd: assert property (p_invalid_cmd) else $error("Invalid pattern accepted.");
  property p_fuse_answer;
    @(posedge core_clk) disable iff (rst)
      fuseTake |=> loadValid && loadData == $past(fuseByte) && ctrl_q == CMD_NONE;
  endproperty
  a_fuse_answer: assert property (p_fuse_answer) else $error("Fuse read wrong.");
  property p_ee_block;
    @(posedge core_clk) disable iff (rst)
      (eepromWriteBusy && idle) |=> !cpuStall && (!loadValid || $past(ctrl_q) != CMD_FUSE);
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("Command taken during EEPROM write.");

endmodule // flash_self_program_ctrl

`default_nettype wire

// ===== inc/flash_self_program_pkg.sv
// Constants, field layouts and carrier types for the flash self-programming controller.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
package flash_self_program_pkg;

  // ----------------------------------------------------------------------
  // Register map and control field positions
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam int          ENABLE_BIT    = 0;
  localparam int          ERASE_BIT     = 1;
  localparam int          WRITE_BIT     = 2;
  localparam int          FUSE_BIT      = 3;
  localparam int          CLEAR_BIT     = 4;
  localparam int          SIG_BIT       = 5;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // Accepted command patterns, low six bits of the control register
  // ----------------------------------------------------------------------
  localparam logic [5:0]  CMD_NONE      = 6'h00;
  localparam logic [5:0]  CMD_LOAD      = 6'h01;
  localparam logic [5:0]  CMD_ERASE     = 6'h03;
  localparam logic [5:0]  CMD_WRITE     = 6'h05;
  localparam logic [5:0]  CMD_FUSE      = 6'h09;
  localparam logic [5:0]  CMD_CLEAR     = 6'h11;
  localparam logic [5:0]  CMD_SIG       = 6'h21;

  // ----------------------------------------------------------------------
  // Windows in core clock cycles
  // ----------------------------------------------------------------------
  localparam logic [2:0]  STORE_WINDOW  = 3'd4;
  localparam logic [2:0]  LOAD_WINDOW   = 3'd3;

  // ----------------------------------------------------------------------
  // Values returned for empty buffer words and out-of-range signature bytes
  // ----------------------------------------------------------------------
  localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
  localparam logic [7:0]  RESERVED_BYTE = 8'h00;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ERASE = 2'b01,
    OP_WRITE = 2'b10
  } flashOp_t;

  // Request toward the flash array; page is the full pointer page field.
  typedef struct packed {
    logic        busy;
    logic        erase;
    logic        write;
    logic [15:0] page;
  } flashCmd_t;

  // Non-volatile configuration bytes, zero means programmed.
  typedef struct packed {
    logic [7:0] fuseLow;
    logic [7:0] lockBits;
    logic [7:0] fuseExt;
    logic [7:0] fuseHigh;
  } fuseBits_t;

endpackage

// ===== verif/flash_array_model.sv
// Behavioural flash array beyond the self-programming controller.
// Assumes one core clock; answers each erase or write with a one-cycle done pulse.
`timescale 1ns/10ps
`default_nettype none

module flash_array_model
  import flash_self_program_pkg::*;
#(
  parameter int WORD_BITS = 6
)(
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // Controller side
  input  wire flash_self_program_pkg::flashCmd_t flashCmd,
  output logic                                   flashDone,
  output logic [WORD_BITS-1:0]                   flashBufAddr,
  // Bench control
  input  wire logic                              slowAnswer,
  input  wire logic [WORD_BITS-1:0]              probeAddr
);
  logic [7:0] waitCnt_q;
  logic [7:0] limit;

  // A slow answer keeps the stall long enough to read the register mid-operation.
  assign limit        = slowAnswer ? 8'h14 : 8'h01;
  assign flashBufAddr = probeAddr;

  always_ff @(posedge core_clk)
  begin
    if (rst || !flashCmd.busy || flashDone)
    begin
      waitCnt_q <= 8'h00;
      flashDone <= 1'b0;
    end
    else
    begin
      waitCnt_q <= waitCnt_q + 8'h01;
      flashDone <= (waitCnt_q >= limit);
    end
  end
endmodule // flash_array_model

`default_nettype wire

// ===== verif/flash_self_program_ctrl_tb.sv
// Self-checking testbench for the flash self-programming controller.
// Assumes flash_array_model answers erase and write; the bench plays the CPU and APB master.
`timescale 1ns/10ps
`default_nettype none

module flash_self_program_ctrl_tb;
  import flash_self_program_pkg::*;
  // Arbitrary signature bytes; byte i holds A1 plus i.
  localparam logic [47:0] SIG_ROW = 48'hA6A5_A4A3_A2A1;
  localparam fuseBits_t   FUSES   = {8'h62, 8'hFC, 8'hFE, 8'hDF};
  localparam logic [7:0]  BAD [3] = '{8'h07, 8'h0B, 8'h3F};

  logic        core_clk;
  logic        rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        storeReq = 1'b0, loadReq = 1'b0, eepromWriteBusy = 1'b0, slowAnswer = 1'b0;
  logic        pready, pslverr, cpuStall, loadValid, flashDone;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [15:0] pointer = 16'h0000, dataRegisterPair = 16'h0000, flashBufData;
  logic [7:0]  loadData;
  logic [5:0]  probeAddr = 6'h00, flashBufAddr;
  flashCmd_t   flashCmd;
  int          errCount = 0, nCompared = 0, cycles = 0;

  flash_self_program_ctrl i_flash_self_program_ctrl (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .storeReq(storeReq), .loadReq(loadReq), .pointer(pointer),
    .dataRegisterPair(dataRegisterPair), .cpuStall(cpuStall), .loadValid(loadValid),
    .loadData(loadData), .eepromWriteBusy(eepromWriteBusy), .fuseBits(FUSES),
    .signatureRow(SIG_ROW), .flashDone(flashDone), .flashBufAddr(flashBufAddr),
    .flashCmd(flashCmd), .flashBufData(flashBufData));

  flash_array_model i_flash_array_model (
    .core_clk(core_clk), .rst(rst), .flashCmd(flashCmd), .flashDone(flashDone),
    .flashBufAddr(flashBufAddr), .slowAnswer(slowAnswer), .probeAddr(probeAddr));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------
  // Bus, strobe and compare tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      errCount++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= 32'(d);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, CTRL_OFFSET, d, rd, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 8'h00, rd, e);
    chk(rd, 32'(exp));
    chkBit(e, expErr);
  endtask

  task automatic st(input logic [15:0] p, input logic [15:0] d);
    storeReq         <= 1'b1;
    pointer          <= p;
    dataRegisterPair <= d;
    @(posedge core_clk);
    storeReq         <= 1'b0;
    #1;
  endtask

  task automatic ld(input logic [15:0] p, input logic v, input logic [7:0] d);
    loadReq <= 1'b1;
    pointer <= p;
    @(posedge core_clk);
    loadReq <= 1'b0;
    #1;
    chkBit(loadValid, v);
    if (v)
      chk(32'(loadData), 32'(d));
  endtask

  task automatic probe(input logic [5:0] w, input logic [15:0] exp);
    @(posedge core_clk);
    probeAddr <= w;
    @(posedge core_clk);
    #1;
    chk(32'(flashBufData), 32'(exp));
  endtask

  task automatic waitIdle;
    for (int n = 0; n < 100 && cpuStall !== 1'b0; n++)
      @(posedge core_clk);
    #1;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    rdchk(CTRL_OFFSET, CTRL_RESET, 1'b0);
    rdchk(12'h004, 8'h00, 1'b1);
    probe(6'h00, ERASED_WORD);
    foreach (BAD[i])
    begin
      wr(BAD[i]);
      rdchk(CTRL_OFFSET, 8'h00, 1'b0);
    end
    wr(8'hC1);
    rdchk(CTRL_OFFSET, 8'h01, 1'b0);
    repeat (2) @(posedge core_clk);
    rdchk(CTRL_OFFSET, 8'h00, 1'b0);
  endtask

  task automatic t_buffer;
    wr({2'b00, CMD_LOAD});
    st(16'h0087, 16'h1234);
    probe(6'h03, 16'h1234);
    probe(6'h04, ERASED_WORD);
    rdchk(CTRL_OFFSET, 8'h00, 1'b0);
    wr({2'b00, CMD_CLEAR});
    probe(6'h03, ERASED_WORD);
    wr({2'b00, CMD_LOAD});
    repeat (3) @(posedge core_clk);
    st(16'h000C, 16'hAAAA);
    probe(6'h06, 16'hAAAA);
    wr({2'b00, CMD_LOAD});
    repeat (4) @(posedge core_clk);
    st(16'h000A, 16'h4321);
    probe(6'h05, ERASED_WORD);
    wr({2'b00, CMD_CLEAR});
  endtask

  task automatic t_erase;
    slowAnswer <= 1'b1;
    wr({2'b00, CMD_ERASE});
    st(16'h0280, 16'h9999);
    chk(32'(flashCmd), {13'h0, 3'b110, 16'h0005});
    chkBit(cpuStall, 1'b1);
    rdchk(CTRL_OFFSET, {2'b00, CMD_ERASE}, 1'b0);
    chkBit(cpuStall, 1'b1);
    waitIdle();
    chk(32'(flashCmd), {13'h0, 3'b000, 16'h0005});
    rdchk(CTRL_OFFSET, 8'h00, 1'b0);
  endtask

  task automatic t_write;
    slowAnswer <= 1'b0;
    wr({2'b00, CMD_LOAD});
    st(16'h0287, 16'h5A5A);
    wr({2'b00, CMD_WRITE});
    st(16'h0280, 16'h0000);
    chk(32'(flashCmd), {13'h0, 3'b101, 16'h0005});
    chkBit(cpuStall, 1'b1);
    waitIdle();
    chkBit(cpuStall, 1'b0);
    probe(6'h03, ERASED_WORD);
    rdchk(CTRL_OFFSET, 8'h00, 1'b0);
  endtask

  task automatic t_sig;
    wr({2'b00, CMD_SIG});
    st(16'h0000, 16'h7777);
    chkBit(cpuStall, 1'b0);
    probe(6'h00, ERASED_WORD);
    for (int i = 0; i < 6; i++)
    begin
      wr({2'b00, CMD_SIG});
      ld(16'(i), 1'b1, SIG_ROW[8*i +: 8]);
    end
  endtask

  task automatic t_fuse;
    for (int i = 0; i < 4; i++)
    begin
      wr({2'b00, CMD_FUSE});
      ld(16'(i), 1'b1, FUSES[31-8*i -: 8]);
    end
    wr({2'b00, CMD_FUSE});
    repeat (3) @(posedge core_clk);
    ld(16'h0001, 1'b0, 8'h00);
  endtask

  task automatic t_eeprom;
    wr({2'b00, CMD_LOAD});
    st(16'h000E, 16'h5555);
    @(posedge core_clk);
    eepromWriteBusy <= 1'b1;
    repeat (2) @(posedge core_clk);
    probe(6'h07, ERASED_WORD);
    wr({2'b00, CMD_FUSE});
    ld(16'h0001, 1'b0, 8'h00);
    rdchk(CTRL_OFFSET, 8'h00, 1'b0);
    wr({2'b00, CMD_ERASE});
    st(16'h0280, 16'h0000);
    chkBit(cpuStall, 1'b0);
    @(posedge core_clk);
    eepromWriteBusy <= 1'b0;
  endtask

  // A reset in mid-run must empty the buffer and drop the page left by the last operation.
  task automatic t_reset;
    wr({2'b00, CMD_LOAD});
    st(16'h0002, 16'hBEEF);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(32'(flashCmd), 32'h0000_0000);
    chkBit(cpuStall, 1'b0);
    probe(6'h01, ERASED_WORD);
    rdchk(CTRL_OFFSET, CTRL_RESET, 1'b0);
  endtask

  task automatic summarize;
    $display("Compared %0d values, %0d mismatches", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; the ceiling only catches a hang.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errCount++;
      summarize();
    end
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_buffer();
    t_erase();
    t_write();
    t_reset();
    t_sig();
    t_fuse();
    t_eeprom();
    summarize();
  end
endmodule // flash_self_program_ctrl_tb

`default_nettype wire
